// ===== tcc_pkg.sv
package tcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry and responses
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 32;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOWER   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT_UPPER   = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE_LOWER = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE_UPPER = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_A     = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_B     = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_FLAG          = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_COMPARATOR    = 6'h20;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int          FLAG_OVERFLOW_BIT   = 0;
    localparam int          FLAG_CAPTURE_BIT    = 5;
    localparam int          CMP_SELECT_BIT      = 2;
    localparam logic [7:0]  CONTROL_RESET       = 8'h00;
    localparam logic [15:0] COUNT_RESET         = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // counter limits, stopped clock select code and filter length
    localparam logic [15:0] COUNT_MAX           = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM        = 16'h0000;
    localparam logic [15:0] TOP_8BIT            = 16'h00ff;
    localparam logic [15:0] TOP_9BIT            = 16'h01ff;
    localparam logic [15:0] TOP_10BIT           = 16'h03ff;
    localparam logic [2:0]  CLOCK_STOPPED       = 3'h0;
    localparam int          FILTER_SAMPLES      = 4;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } tcc_dir_t;

    typedef enum logic [5:0] {
        TOP_SRC_MAX  = 6'b000001,
        TOP_SRC_8    = 6'b000010,
        TOP_SRC_9    = 6'b000100,
        TOP_SRC_10   = 6'b001000,
        TOP_SRC_CMPA = 6'b010000,
        TOP_SRC_CAPT = 6'b100000
    } tcc_top_src_t;

    typedef struct packed {
        logic       filter_en;
        logic       edge_sel;
        logic       rsvd;
        logic [1:0] wgm_hi;
        logic [2:0] clk_sel;
    } tcc_ctrl_b_t;

    typedef struct packed {
        tcc_top_src_t top_src;
        logic         dual_slope;
        logic         ovf_at_max;
    } tcc_mode_t;

endpackage : tcc_pkg

// ===== tcc_timer.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              timer_tick,
    input  wire logic              capture_pin,
    input  wire logic              comparator_output,
    input  wire logic [15:0]       compare_a_value,
    input  wire logic              capture_irq_ack,
    input  wire logic              overflow_irq_ack,
    output logic [2:0]             clock_select,
    output logic [3:0]             waveform_mode_select,
    output logic [15:0]            timer_count,
    output logic [15:0]            capture_value,
    output logic [15:0]            count_top_value,
    output logic                   count_top,
    output logic                   count_bottom,
    output logic                   count_down,
    output logic                   overflow_irq,
    output logic                   capture_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [1:0]   timer_control_a;
    tcc_ctrl_b_t  timer_control_b;
    logic         comparator_capture_select;
    logic         capture_flag;
    logic         overflow_flag;
    logic         capture_irq_enable;
    logic         overflow_irq_enable;
    logic [7:0]   high_latch;
    tcc_dir_t     dir;
    tcc_mode_t    mode;
    logic         pin_meta;
    logic         pin_sync;
    logic         cmp_meta;
    logic         cmp_sync;
    logic         src_q;
    logic [FILTER_SAMPLES-1:0] filt_hist;
    logic         filt_state;
    logic         det_prev;
    logic [15:0]  next_count;
    tcc_dir_t     next_dir;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic                 wr_take;
    logic                 wr_en;
    logic                 rd_take;
    logic                 wr_mapped;
    logic                 rd_mapped;
    logic [7:0]           wbyte;
    logic [DATA_W-1:0]    next_rdata;

    // address and data are taken together, so a write is a single event
    assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign wr_en         = wr_take & s_axi_wstrb[0];
    assign wbyte         = s_axi_wdata[7:0];
    assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_COUNT_LOWER, OFS_COUNT_UPPER, OFS_CAPTURE_LOWER, OFS_CAPTURE_UPPER,
            OFS_CONTROL_A, OFS_CONTROL_B, OFS_FLAG, OFS_IRQ_MASK, OFS_COMPARATOR: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped
    assign wr_mapped = addr_mapped(s_axi_awaddr);
    assign rd_mapped = addr_mapped(s_axi_araddr);
    logic wr_count_lo;
    logic wr_count_hi;
    logic wr_capt_lo;
    logic wr_capt_hi;
    logic rd_count_lo;
    logic rd_capt_lo;
    assign wr_count_lo = wr_en & (s_axi_awaddr == OFS_COUNT_LOWER);
    assign wr_count_hi = wr_en & (s_axi_awaddr == OFS_COUNT_UPPER);
    assign wr_capt_lo  = wr_en & (s_axi_awaddr == OFS_CAPTURE_LOWER);
    assign wr_capt_hi  = wr_en & (s_axi_awaddr == OFS_CAPTURE_UPPER);
    assign rd_count_lo = rd_take & (s_axi_araddr == OFS_COUNT_LOWER);
    assign rd_capt_lo  = rd_take & (s_axi_araddr == OFS_CAPTURE_LOWER);

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    assign waveform_mode_select = {timer_control_b.wgm_hi, timer_control_a};
    assign clock_select         = timer_control_b.clk_sel;

    always_comb begin
        case (waveform_mode_select)
            4'h1:    mode = '{top_src: TOP_SRC_8,    dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'h2:    mode = '{top_src: TOP_SRC_9,    dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'h3:    mode = '{top_src: TOP_SRC_10,   dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'h4:    mode = '{top_src: TOP_SRC_CMPA, dual_slope: 1'b0, ovf_at_max: 1'b1};
            4'h5:    mode = '{top_src: TOP_SRC_8,    dual_slope: 1'b0, ovf_at_max: 1'b0};
            4'h6:    mode = '{top_src: TOP_SRC_9,    dual_slope: 1'b0, ovf_at_max: 1'b0};
            4'h7:    mode = '{top_src: TOP_SRC_10,   dual_slope: 1'b0, ovf_at_max: 1'b0};
            4'h8:    mode = '{top_src: TOP_SRC_CAPT, dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'h9:    mode = '{top_src: TOP_SRC_CMPA, dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'ha:    mode = '{top_src: TOP_SRC_CAPT, dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'hb:    mode = '{top_src: TOP_SRC_CMPA, dual_slope: 1'b1, ovf_at_max: 1'b0};
            4'hc:    mode = '{top_src: TOP_SRC_CAPT, dual_slope: 1'b0, ovf_at_max: 1'b1};
            4'he:    mode = '{top_src: TOP_SRC_CAPT, dual_slope: 1'b0, ovf_at_max: 1'b0};
            4'hf:    mode = '{top_src: TOP_SRC_CMPA, dual_slope: 1'b0, ovf_at_max: 1'b0};
            default: mode = '{top_src: TOP_SRC_MAX,  dual_slope: 1'b0, ovf_at_max: 1'b0};
        endcase
    end

    logic capture_is_top;
    assign capture_is_top = (mode.top_src == TOP_SRC_CAPT);

    always_comb begin
        case (mode.top_src)
            TOP_SRC_8:    count_top_value = TOP_8BIT;
            TOP_SRC_9:    count_top_value = TOP_9BIT;
            TOP_SRC_10:   count_top_value = TOP_10BIT;
            TOP_SRC_CMPA: count_top_value = compare_a_value;
            TOP_SRC_CAPT: count_top_value = capture_value;
            default:      count_top_value = COUNT_MAX;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter
    logic tick_en;
    logic count_clear;
    logic overflow_evt;

    assign tick_en      = timer_tick & (timer_control_b.clk_sel != CLOCK_STOPPED);
    assign count_top    = (timer_count == count_top_value);
    assign count_bottom = (timer_count == COUNT_BOTTOM);
    assign count_down   = mode.dual_slope & (dir == DIR_DOWN);
    assign count_clear  = tick_en & ~mode.dual_slope & count_top;

    always_comb begin
        next_count = timer_count;
        next_dir   = mode.dual_slope ? dir : DIR_UP;
        if (wr_count_lo) begin
            next_count = {high_latch, wbyte};
        end else if (count_clear) begin
            next_count = COUNT_BOTTOM;
        end else if (tick_en) begin
            if (!mode.dual_slope) begin
                next_count = timer_count + 16'h0001;
                next_dir   = DIR_UP;
            end else if (dir == DIR_UP && count_top) begin
                next_count = timer_count - 16'h0001;
                next_dir   = DIR_DOWN;
            end else if (dir == DIR_DOWN && count_bottom) begin
                next_count = timer_count + 16'h0001;
                next_dir   = DIR_UP;
            end else if (dir == DIR_UP) begin
                next_count = timer_count + 16'h0001;
            end else begin
                next_count = timer_count - 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count <= COUNT_RESET;
            dir         <= DIR_UP;
        end else begin
            timer_count <= next_count;
            dir         <= next_dir;
        end
    end

    // dual slope flags at bottom turnaround, the rest at top or at max
    assign overflow_evt = tick_en & ~wr_count_lo &
                          (mode.dual_slope ? (count_bottom & (dir == DIR_DOWN)) :
                           mode.ovf_at_max ? (timer_count == COUNT_MAX) : count_top);

    ////////////////////////////////////////////////////////////////////////////
    // shared high-byte latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_latch <= 8'h00;
        end else if (wr_count_hi || wr_capt_hi) begin
            high_latch <= wbyte;
        end else if (rd_count_lo) begin
            high_latch <= timer_count[15:8];
        end else if (rd_capt_lo) begin
            high_latch <= capture_value[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture input path
    logic source;
    logic det_level;
    logic capture_evt;

    // first stages feed only the second stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            pin_meta <= capture_pin;
            pin_sync <= pin_meta;
            cmp_meta <= comparator_output;
            cmp_sync <= cmp_meta;
        end
    end

    // a select change can itself look like an edge; software clears after
    assign source = comparator_capture_select ? cmp_sync : pin_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_q      <= 1'b0;
            filt_hist  <= '0;
            filt_state <= 1'b0;
            det_prev   <= 1'b0;
        end else begin
            src_q     <= source;
            det_prev  <= det_level;
            filt_hist <= {filt_hist[FILTER_SAMPLES-2:0], source};
            if (&filt_hist) begin
                filt_state <= 1'b1;
            end else if (~|filt_hist) begin
                filt_state <= 1'b0;
            end
        end
    end

    // filtered path lags the plain one by the four history stages
    assign det_level = timer_control_b.filter_en ? filt_state : src_q;
    assign capture_evt = ~capture_is_top & (det_level != det_prev) &
                         (det_level == timer_control_b.edge_sel);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_value <= COUNT_RESET;
        end else if (capture_evt) begin
            capture_value <= timer_count;
        end else if (wr_capt_lo && capture_is_top) begin
            capture_value <= {high_latch, wbyte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags and interrupt requests
    logic clr_capture;
    logic clr_overflow;

    assign clr_capture  = capture_irq_ack |
                          (wr_en & (s_axi_awaddr == OFS_FLAG) & wbyte[FLAG_CAPTURE_BIT]);
    assign clr_overflow = overflow_irq_ack |
                          (wr_en & (s_axi_awaddr == OFS_FLAG) & wbyte[FLAG_OVERFLOW_BIT]);

    // a new event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_flag  <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            capture_flag  <= capture_evt | (capture_flag & ~clr_capture);
            overflow_flag <= overflow_evt | (overflow_flag & ~clr_overflow);
        end
    end

    assign capture_irq  = capture_flag & capture_irq_enable;
    assign overflow_irq = overflow_flag & overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_a           <= CONTROL_RESET[1:0];
            timer_control_b           <= tcc_ctrl_b_t'(CONTROL_RESET);
            comparator_capture_select <= 1'b0;
            capture_irq_enable        <= 1'b0;
            overflow_irq_enable       <= 1'b0;
        end else if (wr_en) begin
            case (s_axi_awaddr)
                OFS_CONTROL_A: timer_control_a <= wbyte[1:0];
                OFS_CONTROL_B: begin
                    timer_control_b      <= tcc_ctrl_b_t'(wbyte);
                    timer_control_b.rsvd <= 1'b0;
                end
                OFS_IRQ_MASK: begin
                    capture_irq_enable  <= wbyte[FLAG_CAPTURE_BIT];
                    overflow_irq_enable <= wbyte[FLAG_OVERFLOW_BIT];
                end
                OFS_COMPARATOR: comparator_capture_select <= wbyte[CMP_SELECT_BIT];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        next_rdata = '0;
        case (s_axi_araddr)
            OFS_COUNT_LOWER:   next_rdata[7:0] = timer_count[7:0];
            OFS_COUNT_UPPER:   next_rdata[7:0] = high_latch;
            OFS_CAPTURE_LOWER: next_rdata[7:0] = capture_value[7:0];
            OFS_CAPTURE_UPPER: next_rdata[7:0] = high_latch;
            OFS_CONTROL_A:     next_rdata[1:0] = timer_control_a;
            OFS_CONTROL_B:     next_rdata[7:0] = timer_control_b;
            OFS_FLAG: begin
                next_rdata[FLAG_CAPTURE_BIT]  = capture_flag;
                next_rdata[FLAG_OVERFLOW_BIT] = overflow_flag;
            end
            OFS_IRQ_MASK: begin
                next_rdata[FLAG_CAPTURE_BIT]  = capture_irq_enable;
                next_rdata[FLAG_OVERFLOW_BIT] = overflow_irq_enable;
            end
            OFS_COMPARATOR:    next_rdata[CMP_SELECT_BIT] = comparator_capture_select;
            default:           next_rdata = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : tcc_timer

// ===== tcc_assertions.sv
`timescale 1ns/1ps
module tcc_assertions
    import tcc_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              timer_tick,
    input wire logic [2:0]        clock_select,
    input wire logic [15:0]       timer_count,
    input wire logic [15:0]       capture_value,
    input wire logic [15:0]       count_top_value,
    input wire logic              count_top,
    input wire logic              count_bottom,
    input wire logic              count_down
);
    // any taken write may legally move count, capture or mode
    wire wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_tick;
        timer_tick && clock_select != CLOCK_STOPPED && !wr && !count_top && !count_bottom;
    endsequence
    sequence s_count_write;
        wr && s_axi_awaddr == OFS_COUNT_LOWER;
    endsequence
    a_bottom_flag: assert property (count_bottom == (timer_count == COUNT_BOTTOM))
        else $error("bottom flag wrong");
    a_top_flag: assert property (count_top == (timer_count == count_top_value))
        else $error("top flag wrong");
    a_count_step: assert property (s_tick |=> timer_count ==
        ($past(count_down) ? $past(timer_count) - 16'h1 : $past(timer_count) + 16'h1))
        else $error("count step wrong");
    a_stopped_hold: assert property (clock_select == CLOCK_STOPPED && !wr |=> $stable(timer_count))
        else $error("stopped counter moved");
    a_write_wins: assert property (s_count_write |=> timer_count[7:0] == $past(s_axi_wdata[7:0]))
        else $error("count write lost");
    a_capture_copy: assert property ($changed(capture_value) && !$past(wr) |-> capture_value == $past(timer_count))
        else $error("capture value not the count");
    a_write_answer: assert property (wr |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
endmodule : tcc_assertions

bind tcc_timer tcc_assertions chk_u (.*);

// ===== tcc_partner.sv
`timescale 1ns/1ps
module tcc_partner (
    output logic capture_pin,
    output logic comparator_output
);
    initial begin
        capture_pin = 1'b0;
        comparator_output = 1'b0;
    end
    // levels are async to the timer clock, so move them off the edge
    task pin(input logic v); #2 capture_pin = v; endtask : pin
    task cmp(input logic v); #2 comparator_output = v; endtask : cmp
    task glitch(input int ns); #2 capture_pin = ~capture_pin; #(ns) capture_pin = ~capture_pin; endtask : glitch
endmodule : tcc_partner

// ===== tcc_timer_tb.sv
`timescale 1ns/1ps
module tcc_timer_tb
    import tcc_pkg::*;
;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, timer_tick = 0, capture_irq_ack = 0, overflow_irq_ack = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [DATA_W-1:0] s_axi_wdata = 0, rdq;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] compare_a_value = 16'h0;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_pin, comparator_output;
    wire count_top, count_bottom, count_down, overflow_irq, capture_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [DATA_W-1:0] s_axi_rdata;
    wire [2:0] clock_select;
    wire [3:0] waveform_mode_select;
    wire [15:0] timer_count, capture_value, count_top_value;
    int errors = 0, n_tests = 0;
    tcc_timer dut_u (.*);
    tcc_partner p_u (.capture_pin(capture_pin), .comparator_output(comparator_output));
    always #2.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task results;
        $display("counts: errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // ready is judged at the falling edge, where it is settled for the next rising edge
    task wt(input int s);
        int i;
        logic r;
        for (i = 0; i < 64; i++) begin
            @(negedge aclk);
            case (s)
                0: r = s_axi_awready && s_axi_wready;
                1: r = s_axi_bvalid;
                2: r = s_axi_arready;
                default: r = s_axi_rvalid;
            endcase
            if (r === 1'b1) break;
        end
        if (i == 64) begin
            errors++;
            results();
        end
        rdq = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
    endtask : wt
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        wt(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        wt(1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wt(2);
        s_axi_arvalid <= 1'b0;
        wt(3);
        s_axi_rready <= 1'b0;
        chk(rdq, {24'h0, e});
    endtask : rd
    task tk(input int n);
        repeat (n) begin
            @(posedge aclk);
            timer_tick <= 1'b1;
        end
        @(posedge aclk);
        timer_tick <= 1'b0;
    endtask : tk
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wr(OFS_IRQ_MASK, 8'h21);
        rd(OFS_CONTROL_B, 8'h00);
        rd(6'h24, 8'h00);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(OFS_COUNT_UPPER, 8'h12);
        wr(OFS_COUNT_LOWER, 8'h34);
        tk(5);
        rd(OFS_COUNT_LOWER, 8'h34);
        rd(OFS_COUNT_UPPER, 8'h12);
        wr(OFS_CONTROL_B, 8'h01);
        tk(20);
        rd(OFS_COUNT_LOWER, 8'h48);
        $display("test done: byte access and counting");
        // tick stays high across the write, the write must win
        timer_tick <= 1'b1;
        wr(OFS_COUNT_UPPER, 8'hff);
        wr(OFS_COUNT_LOWER, 8'hff);
        timer_tick <= 1'b0;
        wr(OFS_FLAG, 8'h01);
        chk(overflow_irq, 0);
        wr(OFS_COUNT_LOWER, 8'hff);
        tk(1);
        @(negedge aclk);
        chk(overflow_irq, 1);
        rd(OFS_COUNT_LOWER, 8'h00);
        @(posedge aclk);
        overflow_irq_ack <= 1'b1;
        @(posedge aclk);
        overflow_irq_ack <= 1'b0;
        @(negedge aclk);
        chk(overflow_irq, 0);
        wr(OFS_CONTROL_A, 8'h01);
        wr(OFS_COUNT_LOWER, 8'hf0);
        tk(30);
        rd(OFS_COUNT_LOWER, 8'hf0);
        chk(count_down, 1);
        wr(OFS_CONTROL_A, 8'h00);
        $display("test done: overflow and dual slope");
        wr(OFS_CONTROL_B, 8'h41);
        p_u.pin(1);
        repeat (10) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf0);
        rd(OFS_CAPTURE_UPPER, 8'h00);
        chk(capture_irq, 1);
        @(posedge aclk);
        capture_irq_ack <= 1'b1;
        @(posedge aclk);
        capture_irq_ack <= 1'b0;
        @(negedge aclk);
        chk(capture_irq, 0);
        tk(4);
        p_u.pin(0);
        repeat (10) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf0);
        wr(OFS_CONTROL_B, 8'h01);
        p_u.pin(1);
        repeat (10) @(negedge aclk);
        p_u.pin(0);
        repeat (10) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf4);
        $display("test done: capture edges");
        wr(OFS_CONTROL_B, 8'hc1);
        tk(1);
        p_u.glitch(10);
        repeat (12) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf4);
        p_u.pin(1);
        repeat (12) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf5);
        wr(OFS_COMPARATOR, 8'h04);
        wr(OFS_FLAG, 8'h20);
        chk(capture_irq, 0);
        tk(1);
        p_u.cmp(1);
        repeat (12) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hf6);
        wr(OFS_CAPTURE_LOWER, 8'h11);
        rd(OFS_CAPTURE_LOWER, 8'hf6);
        wr(OFS_CONTROL_B, 8'h19);
        wr(OFS_CAPTURE_UPPER, 8'hab);
        wr(OFS_CAPTURE_LOWER, 8'hcd);
        p_u.cmp(0);
        repeat (12) @(negedge aclk);
        rd(OFS_CAPTURE_LOWER, 8'hcd);
        rd(OFS_CAPTURE_UPPER, 8'hab);
        $display("test done: filter, comparator and capture top");
        s_axi_wstrb <= 4'h0;
        wr(OFS_CONTROL_A, 8'h03);
        s_axi_wstrb <= 4'hf;
        rd(OFS_CONTROL_A, 8'h00);
        compare_a_value <= 16'h0005;
        wr(OFS_CONTROL_B, 8'h09);
        wr(OFS_COUNT_UPPER, 8'h00);
        wr(OFS_COUNT_LOWER, 8'h00);
        tk(8);
        rd(OFS_COUNT_LOWER, 8'h02);
        $display("test done: strobe and compare top");
        results();
    end
endmodule : tcc_timer_tb
